// *** rtl/sram_host_ctl.sv ***
// Host controller driving an asynchronous 128K x 8 static memory
`timescale 1ns/1ps
`include "sram_ctl_params.svh"
module sram_host_ctl #(
  parameter int AW = `SRAM_ADDR_W,
  parameter int DW = `SRAM_DATA_W
) (
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  input  wire logic                 ce,
  input  wire logic                 req_valid,
  output logic                      req_ready,
  input  wire logic                 req_write,
  input  wire logic [AW-1:0]        req_addr,
  input  wire logic [DW-1:0]        req_wdata,
  output logic                      rd_valid,
  output logic      [DW-1:0]        rd_data,
  output sram_ctl_pkg::pins_t       pins,
  input  wire logic [DW-1:0]        dq_i
);
  localparam logic [3:0] C_ACC  = 4'(`SRAM_CYC_ACCESS);
  localparam logic [3:0] C_WP   = 4'(`SRAM_CYC_WPULSE);
  localparam logic [3:0] C_CYC  = 4'(`SRAM_CYC_CYCLE);
  localparam logic [3:0] C_DIS  = 4'(`SRAM_CYC_DIS);

  // Whole state but the captured byte in one record
  typedef struct packed {
    sram_ctl_pkg::state_t st;
    logic [3:0]           cnt;
    sram_ctl_pkg::pins_t  p;
    logic [DW-1:0]        sync1;  // Pin sync stage one, read only by stage two
    logic [DW-1:0]        sync2;  // Pin sync stage two, feeds the capture
    logic                 rdv;
  } regs_t;

  regs_t s_r;    // Registered state
  regs_t s_nxt;  // Next state
  logic          cap;      // Capture strobe

  // Saturating count helper
  function automatic logic [3:0] inc(input logic [3:0] v);
    inc = (v == 4'hF) ? v : 4'(v + 4'h1);
  endfunction

  // Idle pins: memory deselected, host not driving
  function automatic sram_ctl_pkg::pins_t idle_pins(input sram_ctl_pkg::pins_t p);
    idle_pins         = p;
    idle_pins.en_n    = 1'b1;
    idle_pins.store_n = 1'b1;
    idle_pins.oe_n    = 1'b1;
    idle_pins.dq_oe_n = 1'b1;
  endfunction

  // Next state logic
  always_comb begin
    s_nxt     = s_r;
    s_nxt.rdv = 1'b0;
    cap       = 1'b0;
    // Two-flop synchroniser on the data pins; pins are not in our clock domain
    s_nxt.sync1 = dq_i;
    s_nxt.sync2 = s_r.sync1;
    case (s_r.st)
      sram_ctl_pkg::ST_IDLE: begin
        s_nxt.p = idle_pins(s_r.p);
        if (req_valid) begin
          s_nxt.cnt    = 4'h0;
          s_nxt.p.addr = 17'(req_addr);
          s_nxt.p.en_n = 1'b0;
          if (req_write) begin
            // Strobe falls with enable and address; memory never drives
            s_nxt.st        = sram_ctl_pkg::ST_WR;
            s_nxt.p.store_n = 1'b0;
            s_nxt.p.dq_o    = 8'(req_wdata);
            s_nxt.p.dq_oe_n = 1'b0;
          end else begin
            s_nxt.st     = sram_ctl_pkg::ST_RD;
            s_nxt.p.oe_n = 1'b0;
          end
        end
      end
      sram_ctl_pkg::ST_RD: begin
        // Wait access time plus two sync stages
        s_nxt.cnt = inc(s_r.cnt);
        if (s_r.cnt == C_ACC + 4'h1) begin
          cap       = 1'b1;
          s_nxt.rdv = 1'b1;
          s_nxt.cnt = 4'h0;
          s_nxt.p   = idle_pins(s_r.p);
          s_nxt.st  = sram_ctl_pkg::ST_TURN;
        end
      end
      sram_ctl_pkg::ST_WR: begin
        // Address, data, enable held for whole pulse
        s_nxt.cnt = inc(s_r.cnt);
        if (s_r.cnt + 4'h1 >= C_WP && s_r.cnt + 4'h1 >= C_CYC) begin
          s_nxt.cnt       = 4'h0;
          s_nxt.p.store_n = 1'b1;
          s_nxt.p.en_n    = 1'b1;
          s_nxt.p.dq_oe_n = 1'b1;  // Zero data hold needed
          s_nxt.st        = sram_ctl_pkg::ST_IDLE;
        end
      end
      sram_ctl_pkg::ST_TURN: begin
        // Let memory release the bus before any write
        s_nxt.cnt = inc(s_r.cnt);
        if (s_r.cnt + 4'h1 >= C_DIS) begin
          s_nxt.cnt = 4'h0;
          s_nxt.st  = sram_ctl_pkg::ST_IDLE;
        end
      end
      default: begin
        s_nxt.st = sram_ctl_pkg::ST_IDLE;
        s_nxt.p  = idle_pins(s_r.p);
      end
    endcase
  end

  // State register; no clock or refresh ever reaches the memory
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_r           <= '0;
      s_r.st        <= sram_ctl_pkg::ST_IDLE;
      s_r.p.en_n    <= 1'b1;
      s_r.p.store_n <= 1'b1;
      s_r.p.oe_n    <= 1'b1;
      s_r.p.dq_oe_n <= 1'b1;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  sram_rd_capture #(.DW(DW)) u_cap (
    .mclk (mclk),
    .rst_n(rst_n),
    .ce   (ce),
    .load (cap),
    .din  (s_r.sync2),
    .dout (rd_data)
  );

  assign req_ready = (s_r.st == sram_ctl_pkg::ST_IDLE);
  assign rd_valid  = s_r.rdv;
  assign pins      = s_r.p;

  // Assertions
  property p_wr_overlap;
    @(posedge mclk) disable iff (!rst_n)
    (!s_r.p.store_n) |-> (!s_r.p.en_n && !s_r.p.dq_oe_n && s_r.p.oe_n);
  endproperty
  a_wr_overlap: assert property (p_wr_overlap) else $error("strobe without enable");

  property p_addr_stable;
    @(posedge mclk) disable iff (!rst_n)
    (ce && !s_r.p.store_n && !$past(s_r.p.store_n)) |-> $stable(s_r.p.addr);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved in write");

  sequence s_wr_start;
    $fell(s_r.p.store_n);
  endsequence
  property p_wr_width;
    @(posedge mclk) disable iff (!rst_n || !ce)
    s_wr_start |-> (!s_r.p.store_n)[*2];
  endproperty
  a_wr_width: assert property (p_wr_width) else $error("write pulse short");

  property p_no_contend;
    @(posedge mclk) disable iff (!rst_n)
    !(!s_r.p.dq_oe_n && !s_r.p.oe_n);
  endproperty
  a_no_contend: assert property (p_no_contend) else $error("bus contention");

  property p_idle_float;
    @(posedge mclk) disable iff (!rst_n)
    s_r.p.en_n |-> (s_r.p.dq_oe_n && s_r.p.store_n);
  endproperty
  a_idle_float: assert property (p_idle_float) else $error("drive while deselected");

  property p_rd_wait;
    @(posedge mclk) disable iff (!rst_n || !ce)
    $fell(s_r.p.oe_n) |-> !rd_valid[*4] ##1 (!rd_valid ##1 rd_valid);
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read data taken early");

  property p_turn;
    @(posedge mclk) disable iff (!rst_n || !ce)
    $rose(s_r.p.oe_n) |-> s_r.p.dq_oe_n;
  endproperty
  a_turn: assert property (p_turn) else $error("driven at release");

  property p_strobe_en;
    @(posedge mclk) disable iff (!rst_n)
    $fell(s_r.p.store_n) |-> $fell(s_r.p.en_n);
  endproperty
  a_strobe_en: assert property (p_strobe_en) else $error("strobe not with enable");
endmodule

// *** rtl/sram_ctl_params.svh ***
// Timing and geometry constants for the static memory controller
`ifndef SRAM_CTL_PARAMS_SVH
`define SRAM_CTL_PARAMS_SVH
`define SRAM_CLK_PS        8000
`define SRAM_ADDR_W        17
`define SRAM_DATA_W        8
`define SRAM_T_CYCLE_PS    15000
`define SRAM_T_WPULSE_PS   12000
`define SRAM_T_ACCESS_PS   15000
`define SRAM_T_OEACC_PS    8000
`define SRAM_T_DSU_PS      7000
`define SRAM_T_DIS_PS      7000
`define SRAM_CYC_UP(t)     (((t) + `SRAM_CLK_PS - 1) / `SRAM_CLK_PS)
`define SRAM_CYC_ACCESS    (`SRAM_CYC_UP(`SRAM_T_ACCESS_PS) + 1)
`define SRAM_CYC_WPULSE    `SRAM_CYC_UP(`SRAM_T_WPULSE_PS)
`define SRAM_CYC_CYCLE     `SRAM_CYC_UP(`SRAM_T_CYCLE_PS)
`define SRAM_CYC_DIS       `SRAM_CYC_UP(`SRAM_T_DIS_PS)
`endif

// *** rtl/sram_ctl_pkg.sv ***
// Types shared by the static memory controller
package sram_ctl_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_RD, ST_WR, ST_TURN} state_t;
  // Pin group toward the memory
  typedef struct packed {
    logic [16:0] addr;
    logic        en_n;
    logic        store_n;
    logic        oe_n;
    logic [7:0]  dq_o;
    logic        dq_oe_n;
  } pins_t;
endpackage

// *** rtl/sram_rd_capture.sv ***
// Read data capture register with hold
`timescale 1ns/1ps
module sram_rd_capture #(
  parameter int DW = 8
) (
  input  wire logic          mclk,
  input  wire logic          rst_n,
  input  wire logic          ce,
  input  wire logic          load,
  input  wire logic [DW-1:0] din,
  output logic      [DW-1:0] dout
);
  logic [DW-1:0] q_r;     // Captured byte

  // Load on request, hold otherwise
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q_r <= '0;
    end else if (ce && load) begin
      q_r <= din;
    end
  end

  assign dout = q_r;
endmodule

// *** sim/sram_mem_model.sv ***
// Behavioural model of the 128K x 8 static memory on the host's pins
`timescale 1ns/1ps
module sram_mem_model #(
  parameter int T_ACC = 15
) (
  input  wire logic [16:0] addr,
  input  wire logic        en_n,
  input  wire logic        store_n,
  input  wire logic        oe_n,
  input  wire logic [7:0]  dq_w,
  input  wire logic        dq_w_oe_n,
  output logic      [7:0]  dq_r,
  output logic             clash
);
  logic [7:0]  mem [int];  // Sparse store, static, no refresh
  logic [7:0]  last;       // Last byte shown on the pins
  logic [16:0] wa;         // Address seen during the overlap
  logic [7:0]  wd;         // Data seen during the overlap
  wire         wr = !en_n && !store_n;          // Write overlap
  wire         rd = !en_n && store_n && !oe_n;  // Read mode only
  initial begin
    last  = 8'h00;
    clash = 1'h0;
  end
  // Follow the pins through the overlap; the byte lands at its end
  always @* begin
    if (wr) begin
      wa = addr;
      wd = dq_w;
    end
  end
  // Unknown address at power-up is skipped, not stored
  always @(negedge wr) begin
    if (!$isunknown(wa)) mem[wa] = wd;
  end
  // Floating pins show the inverse of the last byte, so no stale match
  always @(rd or addr) begin
    dq_r = ~last;  // Floated or in access; no hold given
    if (rd) begin
      #(T_ACC);
      if (rd) begin
        last = mem.exists(addr) ? mem[addr] : 8'h00;
        dq_r = last;  // Slowest access figure
      end
    end
  end
  // Latch any contention for the bench to see
  always @* begin
    if (rd && !dq_w_oe_n) clash = 1'h1;
  end
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench for the static memory host controller
`timescale 1ns/1ps
module tb_top;
  logic                mclk;
  logic                rst_n;
  logic                ce;
  logic                req_valid;
  logic                req_ready;
  logic                req_write;
  logic [16:0]         req_addr;
  logic [7:0]          req_wdata;
  logic                rd_valid;
  logic [7:0]          rd_data;
  sram_ctl_pkg::pins_t pins;
  logic [7:0]          dq_i;
  logic                clash;
  int                  n_mismatch;
  int                  checks_done;
  int                  wlow;  // Cycles with the strobe low
  logic [16:0]         waddr; // Address of the request last taken
  sram_host_ctl sram_host_ctl_inst (.mclk(mclk), .rst_n(rst_n), .ce(ce),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .rd_valid(rd_valid),
    .rd_data(rd_data), .pins(pins), .dq_i(dq_i));
  sram_mem_model sram_mem_model_inst (.addr(pins.addr), .en_n(pins.en_n),
    .store_n(pins.store_n), .oe_n(pins.oe_n), .dq_w(pins.dq_o),
    .dq_w_oe_n(pins.dq_oe_n), .dq_r(dq_i), .clash(clash));
  // Compare and count
  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One request; stall holds the clock enable low right after it is taken
  task automatic op(input logic w, input logic [16:0] a, input logic [7:0] d,
                    input int stall, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge mclk);  // Edge between requests, so valid never drops and rises at once
    #1;
    req_valid = 1'h1;
    req_write = w;
    req_addr  = a;
    req_wdata = d;
    while (req_ready !== 1'h1) begin  // Held while refused
      @(posedge mclk);
      #1;
      n++;
      if (n > 20) begin
        n_mismatch++;  // Timed out waiting for ready
        finish_test();
      end
    end
    @(posedge mclk);
    #1;
    req_valid = 1'h0;
    waddr     = a;
    chk(req_ready, 1'h0);  // Busy once taken
    n = 0;
    ce = (stall == 0);
    while (!w && rd_valid !== 1'h1 && n < 20) begin
      @(posedge mclk);
      #1;
      n++;
      if (n >= stall) ce = 1'h1;
    end
    if (!w) chk(n, 5 + stall);  // Access plus two sync stages, frozen edges add
    if (n == 20) begin
      n_mismatch++;  // Timed out waiting for read data
      finish_test();
    end
    q = rd_data;
  endtask
  // Idle pins after reset: memory deselected, host not driving
  task automatic sc_idle();
    chk({pins.en_n, pins.store_n, pins.oe_n, pins.dq_oe_n}, 4'hF);
  endtask
  // Corner addresses written back to back, then read back to back
  task automatic sc_bounds();
    logic [16:0] a [4] = '{17'h00000, 17'h1FFFF, 17'h0AAAA, 17'h15555};
    logic [7:0]  d [4] = '{8'hA5, 8'h5A, 8'h3C, 8'hC3};
    logic [7:0]  q;
    foreach (a[i]) op(1'h1, a[i], d[i], 0, q);
    foreach (a[i]) begin
      op(1'h0, a[i], 8'h00, 0, q);
      chk(q, d[i]);
    end
  endtask
  // Overwrite one byte and read it with a clock-enable stall
  task automatic sc_overwrite();
    logic [7:0] q;
    op(1'h1, 17'h00000, 8'h81, 0, q);
    op(1'h0, 17'h00000, 8'h00, 3, q);
    chk(q, 8'h81);
    op(1'h0, 17'h1FFFF, 8'h00, 0, q);
    chk(q, 8'h5A);  // Neighbour untouched
  endtask
  // Strobe width, enable overlap, steady address, no drive during reads; mid-cycle, settled
  always @(negedge mclk) begin
    if (pins.store_n === 1'h0) begin
      wlow++;
      chk({pins.en_n, pins.dq_oe_n}, 2'h0);
      chk(pins.addr, waddr);
    end else if (wlow != 0) begin
      chk(wlow >= 2, 1'h1);
      wlow = 0;
    end
    if (pins.oe_n === 1'h0) chk(pins.dq_oe_n, 1'h1);
  end
  // Free-running clock, 8 ns period
  initial begin
    mclk = 1'h0;
    forever #4 mclk = ~mclk;
  end
  // Main sequence
  initial begin
    rst_n       = 1'h0;
    ce          = 1'h1;
    req_valid   = 1'h0;
    req_write   = 1'h0;
    req_addr    = 17'h00000;
    req_wdata   = 8'h00;
    n_mismatch  = 0;
    checks_done = 0;
    wlow        = 0;
    waddr       = 17'h00000;
    repeat (10) @(posedge mclk);
    #1;
    rst_n = 1'h1;
    sc_idle();
    sc_bounds();
    sc_overwrite();
    chk(clash, 1'h0);
    finish_test();
  end
endmodule
